// ---- bench/host_processor_bus_interface_test.sv ----
// self-checking bench for the host parallel port in all four strap modes
// assumes the ram model answers every request on the memory side
`timescale 1ns/1ps
`default_nettype none
module host_processor_bus_interface_test;
  typedef struct packed {
    logic        we;
    logic [10:0] a;
    logic [7:0]  d;
  } hpb_note_s;
  logic        clock_i, reset_i, fam, tim, dsel, wre, rdrw, cs_n, ale, doe, rdy_n, rdy_oe;
  logic        dclk, req, we, ack;
  logic [10:0] ad, maddr;
  logic [7:0]  hd, dout, mwd, rd;
  logic [7:0]  shadow [2048];
  hpb_note_s   notes [$];
  hpb_note_s   n;
  int          failures, num_checks, acks;
  wire [7:0]   dl = (doe === 1'b1) ? dout : hd;

  hpb_host_port hpb_host_port_inst (
    .clock_i(clock_i), .reset_i(reset_i), .host_family_select_i(fam),
    .timing_select_i(tim), .divider_select_i(dsel), .write_n_eclock_i(wre),
    .read_n_rw_i(rdrw), .chip_select_n_i(cs_n), .addr_latch_i(ale),
    .address_lines_i(ad), .data_lines_i(dl), .data_lines_o(dout),
    .data_lines_oe_o(doe), .ready_ack_n_o(rdy_n), .ready_ack_oe_o(rdy_oe),
    .divided_clock_o(dclk), .mem_req_o(req), .mem_we_o(we), .mem_addr_o(maddr),
    .mem_wdata_o(mwd), .mem_ack_i(ack), .mem_rdata_i(rd));
  hpb_ram_model hpb_ram_model_inst (
    .clock_i(clock_i), .req_i(req), .we_i(we), .addr_i(maddr), .wdata_i(mwd),
    .ack_o(ack), .rdata_o(rd));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic check(input string nm, input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // strobe-family hosts see the two bytes of each of the four swap word cells exchanged
  function automatic logic [10:0] map(input logic [10:0] a);
    logic [10:0] e;
    e = a & 11'h7fe;
    if (fam && (e == hpb_pkg::SWAP_IRQ_ADDR || e == hpb_pkg::SWAP_STATUS_ADDR ||
        e == hpb_pkg::SWAP_MODE0_ADDR || e == hpb_pkg::SWAP_WDOG_ADDR)) return a ^ 11'h001;
    return a;
  endfunction

  // ---------------------------------------------------------------------------
  // monitor of the memory side
  // ---------------------------------------------------------------------------
  always @(posedge clock_i) begin
    if (req === 1'b1 && ack === 1'b1) begin
      acks++;
      if (notes.size() == 0) check("spare_access", 11'h1, 11'h0);
      else begin
        n = notes.pop_front();
        check("mem_addr", maddr, n.a);
        check("mem_we", we, n.we);
        if (n.we) check("mem_wdata", mwd, n.d);
      end
    end
  end

  task automatic start();
    reset_i = 1'b1;
    wre = !fam;
    repeat (16) @(negedge clock_i);
    check("reset_pins", {rdy_n, rdy_oe, doe}, 11'h4);
    reset_i = 1'b0;
    repeat (6) @(negedge clock_i);
  endtask

  task automatic divchk();
    logic [11:0] s;
    int          d;
    d = dsel ? 1 : 2;
    for (int k = 0; k < 12; k++) begin
      @(negedge clock_i);
      s[k] = dclk;
    end
    for (int k = 0; k < 8; k++) check("div_clock", s[k] ^ s[k + d], 11'h1);
  endtask

  // one host byte access; ok low makes it one the port must ignore
  task automatic acc(input logic w, input logic [10:0] a, input logic [7:0] d, input logic ok);
    int base;
    base = acks;
    if (ok) notes.push_back({w, map(a), d});
    @(negedge clock_i);
    if (!fam && tim) begin
      cs_n = 1'b1;
      ad = {3'h0, ok ? 5'h00 : 5'h01, a[10:8]};
      hd = a[7:0];
      ale = 1'b1;
      repeat (3) @(negedge clock_i);
      ale = 1'b0;
      @(negedge clock_i);
    end else begin
      cs_n = !ok;
      ad = a;
    end
    hd = w ? d : ~d;
    if (fam) begin
      rdrw = !w;
      @(negedge clock_i);
      wre = 1'b1;
    end else if (w) wre = 1'b0;
    else rdrw = 1'b0;
    for (int i = 0; i < 40 && acks == base; i++) @(negedge clock_i);
    if (ok) begin
      if (acks == base) begin
        check("timeout", 11'h0, 11'h1);
        results();
      end
      repeat (2) @(negedge clock_i);
      check("ready_oe", rdy_oe, !tim);
      if (!tim) check("ready_n", rdy_n, 11'h0);
      if (!w) check("rdata", dout, shadow[map(a)]);
      if (!w) check("data_oe", doe, 11'h1);
      if (w) shadow[map(a)] = d;
    end else check("refused", 11'(acks - base), 11'h0);
    wre = !fam;
    rdrw = 1'b1;
    cs_n = 1'b1;
    hd = ~hd;
    repeat (6) @(negedge clock_i);
    check("released", {doe, rdy_oe}, 11'h0);
  endtask

  // ---------------------------------------------------------------------------
  // main sequence: every strap mode, swap cells and a random cell
  // ---------------------------------------------------------------------------
  initial begin
    logic [10:0] al [4];
    reset_i = 1'b1;
    {fam, tim, dsel, wre, rdrw, cs_n, ale} = 7'h0e;
    ad = 11'h000;
    hd = 8'h00;
    failures = 0;
    num_checks = 0;
    acks = 0;
    void'($urandom(32'h1cc4336d));
    al = '{11'h002, 11'h003, 11'h03b, 11'h000};
    for (int m = 0; m < 4; m++) begin
      {fam, tim} = 2'(m);
      dsel = 1'(m);
      al[3] = 11'($urandom);
      start();
      divchk();
      foreach (al[i]) acc(1'b1, al[i], 8'($urandom), 1'b1);
      foreach (al[i]) acc(1'b0, al[i], 8'h00, 1'b1);
      acc(1'b1, 11'h011, 8'h5a, 1'b0);
    end
    results();
  end
endmodule // host_processor_bus_interface_test
`default_nettype wire

// ---- bench/hpb_ram_model.sv ----
// ram side model: byte store that acks each request after 0 to 3 idle cycles
// assumes the request holds until the one-cycle ack pulse
`timescale 1ns/1ps
`default_nettype none
module hpb_ram_model (
  input  wire logic        clock_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [10:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic             ack_o,
  output logic [7:0]       rdata_o
);
  logic [7:0] mem [2048];
  int         wait_q;
  initial begin
    ack_o = 1'b0;
    rdata_o = 8'h00;
    wait_q = 0;
  end
  // read data changes every idle cycle so a late sample cannot pass
  always @(posedge clock_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o) begin
      if (wait_q == 0) begin
        ack_o <= 1'b1;
        rdata_o <= mem[addr_i];
        if (we_i) mem[addr_i] <= wdata_i;
        wait_q <= $urandom_range(3);
      end else wait_q <= wait_q - 1;
    end
  end
endmodule // hpb_ram_model
`default_nettype wire

// ---- common/hpb_pkg.sv ----
// package for the host parallel port: widths, strap coding, state and carrier types
// assumes a single 40 MHz core clock and a ram port that acknowledges with a one-cycle pulse
package hpb_pkg;

  // ---------------------------------------------------------------------------
  // widths and clock
  // ---------------------------------------------------------------------------
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned ADDR_W      = 11;
  localparam int unsigned WIN_W       = 3;
  localparam int unsigned CLK_FREQ_HZ = 40000000;

  // cycles a strap pin needs to pass the synchroniser before it is caught
  localparam logic [1:0]  STRAP_WAIT  = 2'h2;

  // ---------------------------------------------------------------------------
  // divided clock: counter bit that forms the output for each ratio
  // ---------------------------------------------------------------------------
  localparam int unsigned DIV2_BIT    = 0;
  localparam int unsigned DIV4_BIT    = 1;

  // ---------------------------------------------------------------------------
  // word cells whose two bytes are exchanged for the strobe-and-clock family
  // (even byte address of each cell)
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SWAP_IRQ_ADDR    = 11'h002;
  localparam logic [ADDR_W-1:0] SWAP_STATUS_ADDR = 11'h004;
  localparam logic [ADDR_W-1:0] SWAP_MODE0_ADDR  = 11'h006;
  localparam logic [ADDR_W-1:0] SWAP_WDOG_ADDR   = 11'h03a;

  // ---------------------------------------------------------------------------
  // internal chip-select pattern on address pins 7..3 in the multiplexed mode
  // ---------------------------------------------------------------------------
  localparam logic [4:0] INT_CS_PATTERN = 5'h00;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    HPB_IDLE,
    HPB_ACC,
    HPB_HOLD
  } hpb_state_e;

  typedef struct packed {
    logic              fam;
    logic              timing;
    logic              div_sel;
    logic              wr_e;
    logic              rd_rw;
    logic              cs_n;
    logic              ale;
    logic [DATA_W-1:0] data;
    logic [ADDR_W-1:0] addr;
  } hpb_pins_s;

  typedef struct packed {
    hpb_pins_s         sync1;
    hpb_pins_s         sync2;
    logic [1:0]        warm;
    logic              strap_ok;
    logic              fam;
    logic              timing;
    logic [DATA_W-1:0] alat;
    hpb_state_e        st;
    logic              rnw;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
  } hpb_port_s;

  typedef struct packed {
    logic [1:0] cnt;
    logic       clk;
  } hpb_div_s;

endpackage

// ---- core/hpb_clock_divider.sv ----
// divided clock output: input clock divided by two or by four
// assumes div_by2_i is already synchronous to clock_i
`timescale 1ns/1ps
`default_nettype none

module hpb_clock_divider (
  input  wire logic clock_i,
  input  wire logic reset_i,
  input  wire logic div_by2_i,
  output logic      divided_clock_o
);

  hpb_pkg::hpb_div_s q;
  hpb_pkg::hpb_div_s d;

  // ---------------------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------------------
  always_comb begin
    d     = q;
    d.cnt = q.cnt + 2'h1;
    d.clk = div_by2_i ? d.cnt[hpb_pkg::DIV2_BIT] : d.cnt[hpb_pkg::DIV4_BIT];
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign divided_clock_o = q.clk;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  property p_div2_toggles;
    @(posedge clock_i) disable iff (reset_i)
      (div_by2_i && $past(div_by2_i) && $past(div_by2_i, 2)) |-> (divided_clock_o != $past(divided_clock_o));
  endproperty
  a_div2_toggles: assert property (p_div2_toggles) else $error("divide by two does not toggle");

  property p_div4_period;
    @(posedge clock_i) disable iff (reset_i)
      (!div_by2_i [*4]) ##0 $rose(divided_clock_o) |=> divided_clock_o ##1 !divided_clock_o ##1 !divided_clock_o;
  endproperty
  a_div4_period: assert property (p_div4_period) else $error("divide by four period wrong");

endmodule // hpb_clock_divider

`default_nettype wire

// ---- core/hpb_host_port.sv ----
// host parallel port: strap-configured 8-bit data, 11-bit address bus slave to a ram port
// assumes host pins are asynchronous to clock_i; ram side is on clock_i and acks with a pulse
// Function
// - straps 1 1 select the strobe-and-clock family with fixed timing and no ready handshake.
// - both strobe-and-clock settings use separate eight data and eleven address lines.
// - in the synchronous strobe-and-clock setting the decoder is off and the host drives chip select.
// - straps 1 0 select asynchronous timing where ready completes every access.
// - in the asynchronous strobe-and-clock setting the decoder is off and chip select is external.
// - straps 0 1 select fixed timing without ready over a multiplexed address/data bus.
// - in the multiplexed setting the low address byte is latched by the latch strobe and select is decoded inside.
// - the asynchronous separate-strobe setting uses plain lines, ready and external select.
// - the strobe-and-clock family sees the bytes of the four word cells exchanged.
// - the divided clock is the input clock by two with the select pin high and by four when low.
// - the ready output is a three-state pin acting as ready or data acknowledge.
`timescale 1ns/1ps
`default_nettype none

module hpb_host_port #(
  parameter int unsigned DATA_W = hpb_pkg::DATA_W,
  parameter int unsigned ADDR_W = hpb_pkg::ADDR_W
) (
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  input  wire logic              host_family_select_i,
  input  wire logic              timing_select_i,
  input  wire logic              divider_select_i,
  input  wire logic              write_n_eclock_i,
  input  wire logic              read_n_rw_i,
  input  wire logic              chip_select_n_i,
  input  wire logic              addr_latch_i,
  input  wire logic [ADDR_W-1:0] address_lines_i,
  input  wire logic [DATA_W-1:0] data_lines_i,
  output logic      [DATA_W-1:0] data_lines_o,
  output logic                   data_lines_oe_o,
  output logic                   ready_ack_n_o,
  output logic                   ready_ack_oe_o,
  output logic                   divided_clock_o,
  output logic                   mem_req_o,
  output logic                   mem_we_o,
  output logic      [ADDR_W-1:0] mem_addr_o,
  output logic      [DATA_W-1:0] mem_wdata_o,
  input  wire logic              mem_ack_i,
  input  wire logic [DATA_W-1:0] mem_rdata_i
);

  hpb_pkg::hpb_port_s q;
  hpb_pkg::hpb_port_s d;
  hpb_pkg::hpb_pins_s pins_in;

  logic              mux_mode;
  logic              async_mode;
  logic              sel;
  logic              strobe;
  logic              rnw;
  logic [ADDR_W-1:0] raw_addr;
  logic [ADDR_W-1:0] eff_addr;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // true for either byte of a word cell whose bytes are exchanged
  function automatic logic is_swapped(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] e;
    e = {a[ADDR_W-1:1], 1'b0};
    return (e == hpb_pkg::SWAP_IRQ_ADDR) || (e == hpb_pkg::SWAP_STATUS_ADDR) ||
           (e == hpb_pkg::SWAP_MODE0_ADDR) || (e == hpb_pkg::SWAP_WDOG_ADDR);
  endfunction

  // ---------------------------------------------------------------------------
  // pin gathering and decode of the caught straps
  // ---------------------------------------------------------------------------
  always_comb begin
    pins_in.fam     = host_family_select_i;
    pins_in.timing  = timing_select_i;
    pins_in.div_sel = divider_select_i;
    pins_in.wr_e    = write_n_eclock_i;
    pins_in.rd_rw   = read_n_rw_i;
    pins_in.cs_n    = chip_select_n_i;
    pins_in.ale     = addr_latch_i;
    pins_in.data    = data_lines_i;
    pins_in.addr    = address_lines_i;
  end

  assign mux_mode   = !q.fam && q.timing;
  assign async_mode = !q.timing;

  // separate lines in every mode but the multiplexed one
  assign raw_addr = mux_mode ? {q.sync2.addr[hpb_pkg::WIN_W-1:0], q.alat}
                             : q.sync2.addr;

  // strobe-and-clock family sees the two bytes of a word cell exchanged
  assign eff_addr = (q.fam && is_swapped(raw_addr)) ? {raw_addr[ADDR_W-1:1], ~raw_addr[0]}
                                                    : raw_addr;

  // select from the inside decoder only in multiplexed mode, else from the pin
  assign sel = mux_mode ? (q.sync2.addr[7:3] == hpb_pkg::INT_CS_PATTERN)
                        : !q.sync2.cs_n;

  assign strobe = q.fam ? q.sync2.wr_e : (!q.sync2.wr_e || !q.sync2.rd_rw);
  assign rnw    = q.fam ? q.sync2.rd_rw : !q.sync2.rd_rw;

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    d       = q;
    d.sync1 = pins_in;
    d.sync2 = q.sync1;
    if (!q.strap_ok) begin
      if (q.warm == hpb_pkg::STRAP_WAIT) begin
        d.strap_ok = 1'b1;
        d.fam      = q.sync2.fam;
        d.timing   = q.sync2.timing;
      end else begin
        d.warm = q.warm + 2'h1;
      end
    end
    if (mux_mode && q.sync2.ale) begin
      d.alat = q.sync2.data;
    end
    unique case (q.st)
      hpb_pkg::HPB_IDLE: begin
        if (q.strap_ok && sel && strobe) begin
          d.st    = hpb_pkg::HPB_ACC;
          d.rnw   = rnw;
          d.addr  = eff_addr;
          d.wdata = q.sync2.data;
        end
      end
      hpb_pkg::HPB_ACC: begin
        if (mem_ack_i) begin
          d.st = hpb_pkg::HPB_HOLD;
          if (q.rnw) begin
            d.rdata = mem_rdata_i;
          end
        end
      end
      hpb_pkg::HPB_HOLD: begin
        if (!strobe) begin
          d.st = hpb_pkg::HPB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign mem_req_o       = (q.st == hpb_pkg::HPB_ACC);
  assign mem_we_o        = !q.rnw;
  assign mem_addr_o      = q.addr;
  assign mem_wdata_o     = q.wdata;
  assign data_lines_o    = q.rdata;
  assign data_lines_oe_o = (q.st == hpb_pkg::HPB_HOLD) && q.rnw;

  // three-state ready: driven only in asynchronous modes during an access
  assign ready_ack_oe_o  = q.strap_ok && async_mode && (q.st != hpb_pkg::HPB_IDLE);
  assign ready_ack_n_o   = !(q.st == hpb_pkg::HPB_HOLD);

  hpb_clock_divider u_divider (
    .clock_i         (clock_i),
    .reset_i         (reset_i),
    .div_by2_i       (q.sync2.div_sel),
    .divided_clock_o (divided_clock_o)
  );

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  property p_sync_no_ready;
    q.timing |-> !ready_ack_oe_o;
  endproperty
  a_sync_no_ready: assert property (p_sync_no_ready) else $error("ready driven in fixed timing");

  property p_async_ready;
    (q.strap_ok && !q.timing && q.st == hpb_pkg::HPB_HOLD) |-> (ready_ack_oe_o && !ready_ack_n_o);
  endproperty
  a_async_ready: assert property (p_async_ready) else $error("ready missing in async mode");

  property p_ready_released;
    (q.st == hpb_pkg::HPB_HOLD && !strobe && !q.timing) |=> (!ready_ack_oe_o || ready_ack_n_o);
  endproperty
  a_ready_released: assert property (p_ready_released) else $error("ready held after strobe");

  property p_plain_addr;
    (q.st == hpb_pkg::HPB_IDLE && $past(q.st) == hpb_pkg::HPB_IDLE && d.st == hpb_pkg::HPB_ACC
      && q.fam && !is_swapped(q.sync2.addr)) |=> (mem_addr_o == $past(q.sync2.addr));
  endproperty
  a_plain_addr: assert property (p_plain_addr) else $error("separate address lines not passed");

  property p_ext_select;
    (q.st == hpb_pkg::HPB_IDLE && !mux_mode && q.sync2.cs_n) |=> (q.st == hpb_pkg::HPB_IDLE);
  endproperty
  a_ext_select: assert property (p_ext_select) else $error("access without external select");

  property p_int_decode;
    (q.st == hpb_pkg::HPB_IDLE && mux_mode && q.sync2.addr[7:3] != hpb_pkg::INT_CS_PATTERN)
      |=> (q.st == hpb_pkg::HPB_IDLE);
  endproperty
  a_int_decode: assert property (p_int_decode) else $error("inside decoder took wrong pattern");

  property p_mux_addr;
    (q.st == hpb_pkg::HPB_IDLE && d.st == hpb_pkg::HPB_ACC && mux_mode)
      |=> (mem_addr_o == {$past(q.sync2.addr[2:0]), $past(q.alat)});
  endproperty
  a_mux_addr: assert property (p_mux_addr) else $error("latched low byte not used");

  property p_swap;
    (q.st == hpb_pkg::HPB_IDLE && d.st == hpb_pkg::HPB_ACC && q.fam && is_swapped(raw_addr))
      |=> (mem_addr_o[0] != $past(raw_addr[0]));
  endproperty
  a_swap: assert property (p_swap) else $error("word cell bytes not exchanged");

  property p_mode00;
    (q.strap_ok && !q.fam && !q.timing) |-> (async_mode && !mux_mode);
  endproperty
  a_mode00: assert property (p_mode00) else $error("straps 0 0 not asynchronous plain mode");

  property p_read_data;
    (q.st == hpb_pkg::HPB_ACC && mem_ack_i && q.rnw) |=> (data_lines_oe_o && data_lines_o == $past(mem_rdata_i));
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not presented");

endmodule // hpb_host_port

`default_nettype wire
